/* msv_defs.vh */
`ifndef MSV_DEFS_VH
`define MSV_DEFS_VH
// register word offsets (byte addresses)
`define MSV_REG_CTRL 8'h00
`define MSV_REG_ENABLE 8'h04
`define MSV_REG_MFI_CFG 8'h08
`define MSV_REG_MFI_DLY 8'h0C
`define MSV_REG_ALLOWED 8'h10
`define MSV_REG_WINDOW 8'h14
`define MSV_REG_PAUSE 8'h18
`define MSV_REG_CB_DLY 8'h1C
`define MSV_REG_STATUS 8'h20
`define MSV_REG_REMAIN 8'h24
`define MSV_REG_ACK 8'h28
// control register fields
`define MSV_CTRL_INCH 0
`define MSV_CTRL_INV_START 1
`define MSV_CTRL_INV_STOP 2
`define MSV_CTRL_EMERG_EN 3
`define MSV_CTRL_CB_CONTACT 4
`define MSV_CTRL_W 5
// enable byte per mode: local one [7:0], local two [15:8], auto [23:16]
`define MSV_EN_START_CYC 0
`define MSV_EN_STOP_CYC 1
`define MSV_EN_START_LCD 2
`define MSV_EN_STOP_LCD 3
`define MSV_EN_START_ACYC 4
`define MSV_EN_STOP_ACYC 5
`define MSV_EN_START_DI 6
`define MSV_EN_STOP_DI 7
// multifunction input functions, 4 bits per input, auto ack at bit 12+n
`define MSV_FN_OFF 4'h0
`define MSV_FN_STOP 4'h1
`define MSV_FN_TEST 4'h2
`define MSV_FN_FORCE_LOCAL2 4'h3
`define MSV_FN_EMERG 4'h4
`define MSV_FN_FAULT 4'h5
`define MSV_FN_FAULT_RUN 4'h6
`define MSV_MFI_AUTOACK 12
// reset values
`define MSV_CTRL_RST 5'h00
`define MSV_ENABLE_RST 24'hFFFFFF
`define MSV_MFI_CFG_RST 15'h0000
// operating modes
`define MSV_MODE_LOCAL1 2'h0
`define MSV_MODE_LOCAL2 2'h1
`define MSV_MODE_AUTO 2'h2
// checkback current threshold in percent of rated current
`define MSV_CB_PCT 10'h014
// timing: all delays, windows and pauses count in ticks
`define MSV_CLK_KHZ 10000
`define MSV_TICK_MS 100
`define MSV_TICK_CYC (`MSV_TICK_MS * `MSV_CLK_KHZ)
`endif

/* msv_mfi_chan.v */
`include "msv_defs.vh"
// one multifunction input: delay qualifier and its own fault flag
module msv_mfi_chan #(parameter DW = 8)
(
	input wire clk_sys,
	input wire rst_n,
	input wire tick,
	input wire pinLevel,
	input wire [3:0] func,
	input wire [DW-1:0] delay,
	input wire autoAck,
	input wire motorOn,
	input wire suppress,
	input wire ackPulse,
	output wire qualified,
	output reg fault_q
);
	reg [DW-1:0] hold_q;
	wire runFn;
	wire cond;
	wire faultFn;
	assign runFn = (func == `MSV_FN_FAULT_RUN);
	// fault-while-running watches for the input missing while running
	assign cond = runFn ? (motorOn & ~pinLevel) : pinLevel; // RULE_22
	assign faultFn = (func == `MSV_FN_FAULT) | runFn;
	assign qualified = cond & (hold_q >= delay); // RULE_20

	// own delay counter, restarts whenever the condition drops
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			hold_q <= {DW{1'b0}};
		else if (!cond)
			hold_q <= {DW{1'b0}};
		else if (tick && hold_q != {DW{1'b1}})
			hold_q <= hold_q + 1'b1;
	end

	// set wins over acknowledge so a fresh fault is never lost
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			fault_q <= 1'b0;
		else if (faultFn && qualified && !suppress)
			fault_q <= 1'b1; // RULE_21
		else if (ackPulse || (autoAck && !cond) || !faultFn)
			fault_q <= 1'b0; // RULE_21
	end
endmodule

/* msv_start_slot.v */
// one remembered start, aged in ticks until it leaves the window
module msv_start_slot #(parameter AW = 16)
(
	input wire clk_sys,
	input wire rst_n,
	input wire tick,
	input wire load,
	input wire [AW-1:0] window,
	output reg used_q
);
	reg [AW-1:0] age_q;

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			used_q <= 1'b0;
			age_q <= {AW{1'b0}};
		end
		else if (load)
		begin
			used_q <= 1'b1;
			age_q <= {AW{1'b0}};
		end
		else if (used_q && tick)
		begin
			// aged out: this start no longer counts
			if (age_q + 1'b1 >= window)
				used_q <= 1'b0; // RULE_15
			age_q <= age_q + 1'b1;
		end
	end
endmodule

/* msv_top.v */
// What this block does
// RULE_01 - start inputs act on edges by default
// RULE_02 - inching runs only while DI start held
// RULE_03 - per mode start/stop enables, invert options
// RULE_04 - emergency input rise resets thermal memory
// RULE_05 - emergency input high masks input faults
// RULE_06 - bus emergency only when enabled, on rise
// RULE_07 - bus emergency bit high masks input faults
// RULE_08 - count starts inside configurable window
// RULE_09 - one start left raises prewarning
// RULE_10 - no start left: ignore, raise overrun
// RULE_11 - pause after stop blocks starts, shown
// RULE_12 - zero count and window: pause only
// RULE_13 - count and window set: limit plus pause
// RULE_14 - all zero or partial: limiter inactive
// RULE_15 - old starts age out of window
// RULE_16 - current must exceed threshold after on
// RULE_17 - current must reach zero after off
// RULE_18 - contact checkback read on first input
// RULE_19 - stop, forward, reverse DI; stop always works (the DI stop here acts only while the mode's MSV_EN_STOP_DI bit is set)
// RULE_20 - per input delay, non-fault functions ORed
// RULE_21 - fault input owns flag, optional auto ack
// RULE_22 - fault when input missing while running
// RULE_23 - used inputs leave multifunction, raw kept
// RULE_24 - mode: bus fault, force local, autobit
//
// Added by the designer: the strobed register port and the address map.
`include "msv_defs.vh"
module msv_top #(
	parameter TICK_CYC = `MSV_TICK_CYC,
	parameter MAX_STARTS = 8,
	parameter REVERSING = 0
)
(
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData,
	input wire [5:0] diRaw,
	input wire busFault,
	input wire autoBit,
	input wire prepEmergency,
	input wire cycStart,
	input wire cycStop,
	input wire acycStart,
	input wire acycStop,
	input wire lcdStart,
	input wire lcdStop,
	input wire [9:0] motorCurrent,
	output reg motorOn_q,
	output reg motorReverse_q,
	output reg [1:0] ctrlMode_q,
	output reg thermalReset_q,
	output reg testPosition_q,
	output reg startPrewarn_q,
	output reg startOverrun_q,
	output reg pauseActive_q,
	output reg pauseFlash_q,
	output reg [15:0] pauseRemain_q,
	output reg checkbackFail_q,
	output wire [2:0] mfiFault,
	output reg [5:0] diMonitor_q
);
	localparam CB_IDLE = 2'h0;
	localparam CB_ON = 2'h1;
	localparam CB_OFF = 2'h2;

	reg [`MSV_CTRL_W-1:0] ctrl_q;
	reg [23:0] enable_q;
	reg [14:0] mfiCfg_q;
	reg [23:0] mfiDly_q;
	reg [7:0] allowed_q;
	reg [15:0] window_q;
	reg [15:0] pause_q;
	reg [15:0] cbDelay_q;
	reg [23:0] div_q;
	reg tick_q;
	reg [5:0] startLvl_q;
	reg [2:0] mfiQual_q;
	reg prep_q;
	reg diRun_q;
	reg [1:0] cbState_q;
	reg [15:0] cbTimer_q;
	reg [2:0] mfiAck_q;
	reg [7:0] enSel;
	reg [7:0] usedCount;
	reg [MAX_STARTS-1:0] loadVec;
	reg freeFound;
	integer i;
	wire [2:0] qual;
	wire [MAX_STARTS-1:0] usedVec;
	wire [3:0] fn0;
	wire [3:0] fn1;
	wire [3:0] fn2;
	wire startPol;
	wire stopPol;
	wire fwdLvl;
	wire revLvl;
	wire diStopLvl;
	wire [5:0] startNow;
	wire [5:0] startRise;
	wire startReq;
	wire stopReq;
	wire inchStop;
	wire faultStop;
	wire limitOn;
	wire countFull;
	wire blocked;
	wire startOk;
	wire stopNow;
	wire emLvl;
	wire emRise;
	wire busEm;
	wire suppress;
	wire stopFn;
	wire testFn;
	wire forceFn;
	wire cbOnOk;
	wire cbOffOk;
	wire cbExpire;
	wire [1:0] modeNext;

	// an input used for contact checkback is taken off multifunction duty
	assign fn0 = ctrl_q[`MSV_CTRL_CB_CONTACT] ? `MSV_FN_OFF
		: mfiCfg_q[3:0]; // RULE_23
	assign fn1 = mfiCfg_q[7:4];
	assign fn2 = mfiCfg_q[11:8];

	msv_mfi_chan #(.DW(8)) u_mfi0 (
		.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_q),
		.pinLevel(diRaw[0]), .func(fn0), .delay(mfiDly_q[7:0]),
		.autoAck(mfiCfg_q[`MSV_MFI_AUTOACK]), .motorOn(motorOn_q),
		.suppress(suppress), .ackPulse(mfiAck_q[0]),
		.qualified(qual[0]), .fault_q(mfiFault[0]));
	msv_mfi_chan #(.DW(8)) u_mfi1 (
		.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_q),
		.pinLevel(diRaw[1]), .func(fn1), .delay(mfiDly_q[15:8]),
		.autoAck(mfiCfg_q[`MSV_MFI_AUTOACK+1]), .motorOn(motorOn_q),
		.suppress(suppress), .ackPulse(mfiAck_q[1]),
		.qualified(qual[1]), .fault_q(mfiFault[1]));
	msv_mfi_chan #(.DW(8)) u_mfi2 (
		.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_q),
		.pinLevel(diRaw[2]), .func(fn2), .delay(mfiDly_q[23:16]),
		.autoAck(mfiCfg_q[`MSV_MFI_AUTOACK+2]), .motorOn(motorOn_q),
		.suppress(suppress), .ackPulse(mfiAck_q[2]),
		.qualified(qual[2]), .fault_q(mfiFault[2]));

	// non-fault functions merge; the source input is not kept
	assign stopFn = (qual[0] & fn0 == `MSV_FN_STOP)
		| (qual[1] & fn1 == `MSV_FN_STOP)
		| (qual[2] & fn2 == `MSV_FN_STOP); // RULE_20
	assign testFn = (qual[0] & fn0 == `MSV_FN_TEST)
		| (qual[1] & fn1 == `MSV_FN_TEST)
		| (qual[2] & fn2 == `MSV_FN_TEST); // RULE_20
	assign forceFn = (qual[0] & fn0 == `MSV_FN_FORCE_LOCAL2)
		| (qual[1] & fn1 == `MSV_FN_FORCE_LOCAL2)
		| (qual[2] & fn2 == `MSV_FN_FORCE_LOCAL2); // RULE_20
	assign emLvl = (qual[0] & fn0 == `MSV_FN_EMERG)
		| (qual[1] & fn1 == `MSV_FN_EMERG)
		| (qual[2] & fn2 == `MSV_FN_EMERG);
	assign emRise = |(qual & ~mfiQual_q & {fn2 == `MSV_FN_EMERG,
		fn1 == `MSV_FN_EMERG, fn0 == `MSV_FN_EMERG}); // RULE_04
	assign busEm = ctrl_q[`MSV_CTRL_EMERG_EN];
	assign suppress = emLvl | (busEm & prepEmergency); // RULE_05 RULE_07

	// bus fault first, then forced local, then autobit
	assign modeNext = busFault ? `MSV_MODE_LOCAL1
		: forceFn ? `MSV_MODE_LOCAL2
		: autoBit ? `MSV_MODE_AUTO : `MSV_MODE_LOCAL1; // RULE_24

	// enable byte of the mode in force
	always @*
	begin
		if (ctrlMode_q == `MSV_MODE_LOCAL2)
			enSel = enable_q[15:8]; // RULE_03
		else if (ctrlMode_q == `MSV_MODE_AUTO)
			enSel = enable_q[23:16]; // RULE_03
		else
			enSel = enable_q[7:0]; // RULE_03
	end

	// local inputs: bit 5 stop, bit 4 forward, bit 3 reverse
	assign startPol = ctrl_q[`MSV_CTRL_INV_START];
	assign stopPol = ctrl_q[`MSV_CTRL_INV_STOP];
	assign fwdLvl = diRaw[4] ^ startPol; // RULE_19 RULE_03
	assign revLvl = (REVERSING != 0) & (diRaw[3] ^ startPol); // RULE_19
	assign diStopLvl = diRaw[5] ^ stopPol; // RULE_19 RULE_03
	assign startNow = {revLvl & enSel[`MSV_EN_START_DI],
		fwdLvl & enSel[`MSV_EN_START_DI],
		cycStart & enSel[`MSV_EN_START_CYC],
		acycStart & enSel[`MSV_EN_START_ACYC],
		lcdStart & enSel[`MSV_EN_START_LCD], 1'b0};
	assign startRise = startNow & ~startLvl_q; // RULE_01
	assign startReq = |startRise;
	assign stopReq = (diStopLvl & enSel[`MSV_EN_STOP_DI])
		| (cycStop & enSel[`MSV_EN_STOP_CYC])
		| (acycStop & enSel[`MSV_EN_STOP_ACYC])
		| (lcdStop & enSel[`MSV_EN_STOP_LCD]) | stopFn; // RULE_19

	// inching drops the motor as soon as the DI start level goes
	assign inchStop = ctrl_q[`MSV_CTRL_INCH] & diRun_q
		& ~(motorReverse_q ? startNow[5] : startNow[4]); // RULE_02
	assign faultStop = (|mfiFault) | checkbackFail_q | cbExpire;

	// window limit only with both count and window set
	assign limitOn = (allowed_q != 8'h00) & (window_q != 16'h0000);
	assign countFull = usedCount >= allowed_q; // RULE_10
	assign blocked = pauseActive_q | (limitOn & countFull); // RULE_11
	assign stopNow = stopReq | inchStop | faultStop;
	assign startOk = startReq & ~motorOn_q & ~stopNow & ~blocked;

	// count slots still inside the window; load the first free one
	always @*
	begin
		usedCount = 8'h00;
		loadVec = {MAX_STARTS{1'b0}};
		freeFound = 1'b0;
		for (i = 0; i < MAX_STARTS; i = i + 1)
		begin
			usedCount = usedCount + {7'h00, usedVec[i]}; // RULE_08
			if (!usedVec[i] && !freeFound)
			begin
				freeFound = 1'b1;
				loadVec[i] = startOk & limitOn; // RULE_13 RULE_14
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < MAX_STARTS; g = g + 1)
		begin : gSlot
			msv_start_slot #(.AW(16)) u_slot (
				.clk_sys(clk_sys), .rst_n(rst_n), .tick(tick_q),
				.load(loadVec[g]), .window(window_q),
				.used_q(usedVec[g]));
		end
	endgenerate

	// tick divider: every time base counts in ticks
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			div_q <= 24'h000000;
			tick_q <= 1'b0;
		end
		else if (div_q == TICK_CYC[23:0] - 24'h000001)
		begin
			div_q <= 24'h000000;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 24'h000001;
			tick_q <= 1'b0;
		end
	end

	// motor state, edge history and event outputs
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			motorOn_q <= 1'b0;
			motorReverse_q <= 1'b0;
			diRun_q <= 1'b0;
			ctrlMode_q <= `MSV_MODE_LOCAL1;
			startLvl_q <= 6'h00;
			mfiQual_q <= 3'h0;
			prep_q <= 1'b0;
			thermalReset_q <= 1'b0;
			testPosition_q <= 1'b0;
			startPrewarn_q <= 1'b0;
			startOverrun_q <= 1'b0;
			diMonitor_q <= 6'h00;
		end
		else
		begin
			if (stopNow)
				motorOn_q <= 1'b0; // RULE_19
			else if (startOk)
			begin
				motorOn_q <= 1'b1;
				motorReverse_q <= startRise[5];
				diRun_q <= startRise[5] | startRise[4];
			end
			ctrlMode_q <= modeNext;
			startLvl_q <= startNow;
			mfiQual_q <= qual;
			prep_q <= prepEmergency;
			thermalReset_q <= emRise
				| (busEm & prepEmergency & ~prep_q); // RULE_04 RULE_06
			testPosition_q <= testFn;
			startPrewarn_q <= limitOn
				& (usedCount + 8'h01 == allowed_q); // RULE_09
			startOverrun_q <= startReq & ~motorOn_q & limitOn
				& countFull; // RULE_10
			diMonitor_q <= diRaw; // RULE_23
		end
	end

	// pause after stop; the flash bit toggles once per tick
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pauseRemain_q <= 16'h0000;
			pauseActive_q <= 1'b0;
			pauseFlash_q <= 1'b0;
		end
		else if (motorOn_q && stopNow && pause_q != 16'h0000)
		begin
			pauseRemain_q <= pause_q; // RULE_11 RULE_12
			pauseActive_q <= 1'b1;
		end
		else if (pauseActive_q && tick_q)
		begin
			pauseRemain_q <= pauseRemain_q - 16'h0001;
			pauseActive_q <= (pauseRemain_q != 16'h0001);
			pauseFlash_q <= ~pauseFlash_q & (pauseRemain_q != 16'h0001);
		end
	end

	// checkback by current or by the auxiliary contact on input bit 0
	assign cbOnOk = ctrl_q[`MSV_CTRL_CB_CONTACT] ? diRaw[0]
		: (motorCurrent > `MSV_CB_PCT); // RULE_16 RULE_18
	assign cbOffOk = ctrl_q[`MSV_CTRL_CB_CONTACT] ? ~diRaw[0]
		: (motorCurrent == 10'h000); // RULE_17 RULE_18
	assign cbExpire = (cbState_q == CB_ON) & tick_q & ~cbOnOk
		& (cbTimer_q == 16'h0000);

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cbState_q <= CB_IDLE;
			cbTimer_q <= 16'h0000;
			checkbackFail_q <= 1'b0;
		end
		else
		begin
			case (cbState_q)
			CB_IDLE:
				if (startOk)
				begin
					cbState_q <= CB_ON;
					cbTimer_q <= cbDelay_q;
				end
			CB_ON:
				if (!motorOn_q || cbOnOk)
					cbState_q <= motorOn_q ? CB_IDLE : CB_OFF;
				else if (tick_q)
				begin
					if (cbTimer_q == 16'h0000)
						cbState_q <= CB_IDLE;
					else
						cbTimer_q <= cbTimer_q - 16'h0001;
				end
			default:
				if (cbOffOk)
					cbState_q <= CB_IDLE;
				else if (tick_q)
				begin
					if (cbTimer_q == 16'h0000)
						cbState_q <= CB_IDLE;
					else
						cbTimer_q <= cbTimer_q - 16'h0001;
				end
			endcase
			// a new failure wins over a same-cycle acknowledge
			if (cbExpire || ((cbState_q == CB_OFF) && tick_q
				&& !cbOffOk && cbTimer_q == 16'h0000))
				checkbackFail_q <= 1'b1; // RULE_16 RULE_17
			else if (regWr && regAddr == `MSV_REG_ACK && regWrData[0])
				checkbackFail_q <= 1'b0;
			if (motorOn_q && stopNow && cbState_q != CB_ON)
			begin
				cbState_q <= CB_OFF;
				cbTimer_q <= cbDelay_q;
			end
		end
	end

	// register writes; acknowledge bits are one-cycle pulses
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ctrl_q <= `MSV_CTRL_RST;
			enable_q <= `MSV_ENABLE_RST;
			mfiCfg_q <= `MSV_MFI_CFG_RST;
			mfiDly_q <= 24'h000000;
			allowed_q <= 8'h00;
			window_q <= 16'h0000;
			pause_q <= 16'h0000;
			cbDelay_q <= 16'h0000;
			mfiAck_q <= 3'h0;
		end
		else
		begin
			mfiAck_q <= 3'h0;
			if (regWr)
			begin
				if (regAddr == `MSV_REG_CTRL)
					ctrl_q <= regWrData[`MSV_CTRL_W-1:0]; // RULE_03
				else if (regAddr == `MSV_REG_ENABLE)
					enable_q <= regWrData[23:0]; // RULE_03
				else if (regAddr == `MSV_REG_MFI_CFG)
					mfiCfg_q <= regWrData[14:0];
				else if (regAddr == `MSV_REG_MFI_DLY)
					mfiDly_q <= regWrData[23:0];
				else if (regAddr == `MSV_REG_ALLOWED)
					allowed_q <= regWrData[7:0]; // RULE_08
				else if (regAddr == `MSV_REG_WINDOW)
					window_q <= regWrData[15:0]; // RULE_08
				else if (regAddr == `MSV_REG_PAUSE)
					pause_q <= regWrData[15:0];
				else if (regAddr == `MSV_REG_CB_DLY)
					cbDelay_q <= regWrData[15:0];
				else if (regAddr == `MSV_REG_ACK)
					mfiAck_q <= regWrData[3:1];
			end
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk_sys)
	begin
		if (!rst_n || !regRd)
			regRdData <= 32'h00000000;
		else if (regAddr == `MSV_REG_CTRL)
			regRdData <= {27'h0000000, ctrl_q};
		else if (regAddr == `MSV_REG_ENABLE)
			regRdData <= {8'h00, enable_q};
		else if (regAddr == `MSV_REG_MFI_CFG)
			regRdData <= {17'h00000, mfiCfg_q};
		else if (regAddr == `MSV_REG_MFI_DLY)
			regRdData <= {8'h00, mfiDly_q};
		else if (regAddr == `MSV_REG_ALLOWED)
			regRdData <= {24'h000000, allowed_q};
		else if (regAddr == `MSV_REG_WINDOW)
			regRdData <= {16'h0000, window_q};
		else if (regAddr == `MSV_REG_PAUSE)
			regRdData <= {16'h0000, pause_q};
		else if (regAddr == `MSV_REG_CB_DLY)
			regRdData <= {16'h0000, cbDelay_q};
		else if (regAddr == `MSV_REG_STATUS)
			regRdData <= {usedCount, 2'h0, diMonitor_q, 5'h00,
				mfiFault, checkbackFail_q, pauseActive_q,
				startPrewarn_q, testPosition_q, ctrlMode_q,
				motorReverse_q, motorOn_q};
		else if (regAddr == `MSV_REG_REMAIN)
			regRdData <= {16'h0000, pauseRemain_q}; // RULE_11
		else
			regRdData <= 32'h00000000;
	end
endmodule

/* msv_asserts.sv */
`include "msv_defs.vh"
// sees the top ports only; every check rests while reset is low
module msv_asserts
(
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	input wire [31:0] regRdData,
	input wire busFault,
	input wire motorOn_q,
	input wire [1:0] ctrlMode_q,
	input wire thermalReset_q,
	input wire startOverrun_q,
	input wire pauseActive_q,
	input wire [15:0] pauseRemain_q,
	input wire checkbackFail_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// read data only in the slot after a strobe, so a stale word never leaks
	rd_idle_a:
	assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data outside its slot");
	mode_fault_a:
	assert property (busFault |=> ctrlMode_q == `MSV_MODE_LOCAL1)
		else $error("bus fault did not force local one");
	overrun_pulse_a:
	assert property (startOverrun_q |=> !startOverrun_q)
		else $error("overrun longer than one cycle");
	overrun_refuse_a:
	assert property ($rose(startOverrun_q) |-> !$rose(motorOn_q))
		else $error("refused start ran the motor");
	pause_block_a:
	assert property ($rose(motorOn_q) |-> !$past(pauseActive_q))
		else $error("start taken during pause");
	pause_end_a:
	assert property ($fell(pauseActive_q) |-> pauseRemain_q == 16'h0000)
		else $error("pause ended with time left");
	thermal_pulse_a:
	assert property (thermalReset_q |=> !thermalReset_q)
		else $error("thermal reset longer than one cycle");
	cb_sticky_a:
	assert property (checkbackFail_q && !(regWr && regAddr == `MSV_REG_ACK
		&& regWrData[0]) |=> checkbackFail_q)
		else $error("checkback fail lost without ack");
	cb_stop_a:
	assert property ($rose(checkbackFail_q) |-> ##[0:1] !motorOn_q)
		else $error("motor kept on after checkback fail");
endmodule
bind msv_top msv_asserts u_msv_asserts (.clk_sys(clk_sys), .rst_n(rst_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.regRd(regRd), .regRdData(regRdData), .busFault(busFault),
	.motorOn_q(motorOn_q), .ctrlMode_q(ctrlMode_q),
	.thermalReset_q(thermalReset_q), .startOverrun_q(startOverrun_q),
	.pauseActive_q(pauseActive_q), .pauseRemain_q(pauseRemain_q),
	.checkbackFail_q(checkbackFail_q));

/* msv_plc_model.sv */
// master side of the bus telegram: a level follows its request one cycle later
// or after a lag, so the block meets both a prompt and a slow master
module msv_plc_model
(
	input wire clk_sys,
	input wire rst_n,
	input wire fire,
	input wire [2:0] sel,
	input wire lvl,
	input wire [1:0] lag,
	output logic [6:0] busOut_q
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] selHold_q;
	logic lvlHold_q;
	logic [1:0] lagCnt_q;
	logic pend_q;
	// bit 2 is the prepare bit; it only moves on request, to the level requested
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			busOut_q <= 7'h00;
			pend_q <= 1'b0;
		end
		else if (fire)
		begin
			selHold_q <= sel;
			lvlHold_q <= lvl;
			lagCnt_q <= lag;
			pend_q <= 1'b1;
		end
		else if (pend_q && lagCnt_q == 2'h0)
		begin
			busOut_q[selHold_q] <= lvlHold_q;
			pend_q <= 1'b0;
		end
		else if (pend_q)
			lagCnt_q <= lagCnt_q - 2'h1;
	end
endmodule

/* testbench.sv */
`include "msv_defs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
	logic fire = 1'b0, lvl = 1'b0, curOk = 1'b1;
	logic [1:0] lag = 2'h0;
	logic [2:0] sel = 3'h0;
	logic [5:0] diRaw = 6'h00;
	logic [7:0] regAddr = 8'h00;
	logic [9:0] motorCurrent = 10'h000;
	logic [15:0] curSeed = 16'h1FE2;
	logic [31:0] regWrData = 32'h0;
	logic [31:0] regRdData;
	logic [6:0] busOut;
	logic motorOn_q, thermalReset_q, startPrewarn_q, startOverrun_q;
	logic pauseActive_q, checkbackFail_q;
	logic [1:0] ctrlMode_q;
	logic [15:0] pauseRemain_q;
	logic [2:0] mfiFault;
	logic [5:0] diMonitor_q;
	int err_total = 0, checks = 0, thermCnt = 0, ovrCnt = 0, i;
	msv_plc_model u_msv_plc_model (.clk_sys(clk_sys), .rst_n(rst_n),
		.fire(fire), .sel(sel), .lvl(lvl), .lag(lag), .busOut_q(busOut));
	msv_top #(.TICK_CYC(10)) u_msv_top (.clk_sys(clk_sys), .rst_n(rst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .diRaw(diRaw),
		.busFault(busOut[0]), .autoBit(busOut[1]),
		.prepEmergency(busOut[2]), .cycStart(busOut[3]),
		.cycStop(busOut[4]), .acycStart(busOut[5]), .acycStop(busOut[6]),
		.lcdStart(1'b0), .lcdStop(1'b0), .motorCurrent(motorCurrent),
		.motorOn_q(motorOn_q), .motorReverse_q(), .ctrlMode_q(ctrlMode_q),
		.thermalReset_q(thermalReset_q), .testPosition_q(),
		.startPrewarn_q(startPrewarn_q), .startOverrun_q(startOverrun_q),
		.pauseActive_q(pauseActive_q), .pauseFlash_q(),
		.pauseRemain_q(pauseRemain_q), .checkbackFail_q(checkbackFail_q),
		.mfiFault(mfiFault), .diMonitor_q(diMonitor_q));
	// system clock, 100 ns period
	initial
	begin
		forever #50 clk_sys = ~clk_sys;
	end
	// pulses stand one cycle, so count them; current follows the motor
	always @(posedge clk_sys)
	begin
		thermCnt <= thermCnt + thermalReset_q;
		ovrCnt <= ovrCnt + startOverrun_q;
		curSeed <= lfsr_next(curSeed);
		motorCurrent <= (motorOn_q && curOk) ?
			10'h015 + curSeed[8:0] : 10'h000;
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// force local two is never raised here, so two inputs decide
	function automatic logic [1:0] exp_mode(input logic bf, input logic ab);
		exp_mode = (!bf && ab) ? `MSV_MODE_AUTO : `MSV_MODE_LOCAL1;
	endfunction
	// warn while exactly one allowed start is left
	function automatic logic exp_warn(input int allowed, input int tried);
		exp_warn = (allowed - tried == 1);
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic hang();
		err_total++;
		$display("mismatch %0t wait ran out", $time);
		end_sim();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 cmp(regRdData, e, "read");
	endtask
	// one request to the master model, then time for it to land
	task automatic plc(input logic [2:0] s, input logic v, input logic [1:0] l);
		@(posedge clk_sys);
		fire <= 1'b1;
		sel <= s;
		lvl <= v;
		lag <= l;
		@(posedge clk_sys);
		fire <= 1'b0;
		repeat (l + 3) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse(input logic [2:0] s);
		plc(s, 1'b1, 2'h0);
		plc(s, 1'b0, 2'h0);
	endtask
	// inputs move on an edge; the margin covers a tick of input delay
	task automatic di(input logic [5:0] v);
		@(posedge clk_sys);
		diRaw <= v;
		repeat (12) @(posedge clk_sys);
		#1;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(`MSV_REG_ENABLE, 32'h00FFFFFF);
		rd(`MSV_REG_CTRL, 32'h0);
		rd(8'h3C, 32'h0);
		wr(`MSV_REG_CB_DLY, 32'h4);
		plc(3'h0, 1'b1, 2'h0);
		plc(3'h1, 1'b1, 2'h2);
		cmp(ctrlMode_q, exp_mode(1'b1, 1'b1), "bus fault");
		plc(3'h0, 1'b0, 2'h0);
		cmp(ctrlMode_q, exp_mode(1'b0, 1'b1), "auto");
		plc(3'h3, 1'b1, 2'h2);
		plc(3'h3, 1'b0, 2'h0);
		repeat (20) @(posedge clk_sys);
		#1 cmp(motorOn_q, 1'b1, "pulse start");
		cmp(startPrewarn_q, 1'b0, "no limit");
		pulse(3'h6);
		cmp(motorOn_q, 1'b0, "acyc stop");
		wr(`MSV_REG_ENABLE, 32'h00FEFFFF);
		pulse(3'h3);
		cmp(motorOn_q, 1'b0, "start masked");
		wr(`MSV_REG_ENABLE, 32'h00FFFFFF);
		wr(`MSV_REG_ALLOWED, 32'h2);
		wr(`MSV_REG_WINDOW, 32'h28);
		for (i = 0; i < 3; i++)
		begin
			pulse(3'h3);
			cmp(motorOn_q, i < 2, "limit");
			cmp(startPrewarn_q, exp_warn(2, i + 1), "warn");
			cmp(ovrCnt, i / 2, "overrun");
			pulse(3'h6);
		end
		repeat (420) @(posedge clk_sys);
		pulse(3'h3);
		cmp(motorOn_q, 1'b1, "aged out");
		pulse(3'h6);
		cmp(checkbackFail_q, 1'b0, "off checkback");
		wr(`MSV_REG_ALLOWED, 32'h0);
		wr(`MSV_REG_WINDOW, 32'h0);
		wr(`MSV_REG_PAUSE, 32'h5);
		pulse(3'h3);
		pulse(3'h6);
		cmp(pauseActive_q, 1'b1, "pause");
		cmp(pauseRemain_q - 16'h1 < 16'h5, 1'b1, "remain");
		pulse(3'h3);
		cmp(motorOn_q, 1'b0, "start in pause");
		for (i = 0; i < 80 && pauseActive_q !== 1'b0; i++)
			#100;
		if (i == 80)
			hang();
		pulse(3'h3);
		cmp(motorOn_q, 1'b1, "after pause");
		wr(`MSV_REG_PAUSE, 32'h0);
		pulse(3'h6);
		curOk <= 1'b0;
		pulse(3'h3);
		for (i = 0; i < 80 && checkbackFail_q !== 1'b1; i++)
			#100;
		if (i == 80)
			hang();
		cmp(motorOn_q, 1'b0, "checkback stop");
		curOk <= 1'b1;
		wr(`MSV_REG_ACK, 32'h1);
		di(6'h00);
		cmp(checkbackFail_q, 1'b0, "checkback ack");
		plc(3'h1, 1'b0, 2'h0);
		wr(`MSV_REG_CTRL, 32'h1);
		di(6'h10);
		cmp(motorOn_q, 1'b1, "inch on");
		cmp(diMonitor_q, 6'h10, "raw");
		rd(`MSV_REG_STATUS, 32'h00100001);
		di(6'h00);
		cmp(motorOn_q, 1'b0, "inch off");
		di(6'h10);
		di(6'h30);
		cmp(motorOn_q, 1'b0, "di stop");
		di(6'h00);
		wr(`MSV_REG_CTRL, 32'h8);
		wr(`MSV_REG_MFI_CFG, 32'h54);
		di(6'h01);
		cmp(thermCnt, 1, "emergency input");
		di(6'h03);
		cmp(mfiFault, 3'h0, "fault masked");
		di(6'h02);
		cmp(mfiFault, 3'h2, "fault set");
		di(6'h00);
		wr(`MSV_REG_ACK, 32'h4);
		di(6'h00);
		cmp(mfiFault, 3'h0, "fault ack");
		plc(3'h2, 1'b1, 2'h0);
		cmp(thermCnt, 2, "bus emergency");
		di(6'h02);
		cmp(mfiFault, 3'h0, "bus masked");
		di(6'h00);
		plc(3'h2, 1'b0, 2'h0);
		wr(`MSV_REG_CTRL, 32'h0);
		plc(3'h2, 1'b1, 2'h0);
		cmp(thermCnt, 2, "emergency off");
		wr(`MSV_REG_CTRL, 32'h10);
		di(6'h10);
		repeat (50) @(posedge clk_sys);
		#1 cmp(checkbackFail_q, 1'b1, "contact");
		end_sim();
	end
endmodule
